// ===== pci_power_mgmt_capability_test.sv
// testbench for the power management capability structure
// assumes ppm_pkg, ppm_capability and ppm_host are compiled first
`timescale 1ns/100ps
module pci_power_mgmt_capability_test;
  logic                  clk_in;
  logic                  reset_n_in;
  logic                  power_on_n_in;
  logic                  strap;
  logic                  wake;
  logic [31:0]           rdata;
  logic [31:0]           rdata_fs;
  logic                  hit;
  logic                  pme_n;
  logic                  pme_oe;
  logic [1:0]            ps;
  logic [1:0]            ps_fs;
  ppm_pkg::ppm_cfg_req_t req;
  int                    error_cnt = 0;
  int                    n_checks = 0;
  int                    cycles = 0;
  logic [31:0]           d;
  logic                  h;
  // full-speed variant: D2 unsupported, so that write is dropped
  logic [1:0]            fs_exp [4] = '{2'h0, 2'h1, 2'h1, 2'h3};

  ppm_host u_ppm_host (.clk_in(clk_in), .rdata_in(rdata), .hit_in(hit), .req_out(req));

  ppm_capability u_ppm_capability (.clk_in(clk_in), .reset_n_in(reset_n_in), .power_on_n_in(power_on_n_in),
    .d3cold_strap_pin_in(strap), .cfg_req_in(req), .cfg_rdata_out(rdata), .cfg_hit_out(hit),
    .wake_event_in(wake), .pme_n_out(pme_n), .pme_oe_out(pme_oe), .power_state_out(ps));

  ppm_capability #(.HIGH_SPEED(1'b0)) u_ppm_capability_fs (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .power_on_n_in(power_on_n_in), .d3cold_strap_pin_in(1'b0), .cfg_req_in(req), .cfg_rdata_out(rdata_fs),
    .cfg_hit_out(), .wake_event_in(wake), .pme_n_out(), .pme_oe_out(), .power_state_out(ps_fs));

  // ==========================================
  // clock and hang guard
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      close_out();
    end
  end

  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic eh);
    u_ppm_host.xfer(1'b0, a, 4'hF, 32'h0, d, h);
    chk(d & m, e);
    chk({31'h0, h}, {31'h0, eh});
  endtask : rdchk

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
    u_ppm_host.xfer(1'b1, a, be, wd, d, h);
  endtask : wr

  task automatic pulse_wake;
    @(negedge clk_in);
    wake = 1'b1;
    @(negedge clk_in);
    wake = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask : pulse_wake

  // po high also pulses power-on reset, which relatches the strap
  task automatic rst_pulse(input logic po);
    @(negedge clk_in);
    reset_n_in = 1'b0;
    power_on_n_in = ~po;
    repeat (2) @(negedge clk_in);
    reset_n_in = 1'b1;
    power_on_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
  endtask : rst_pulse

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // ==========================================
  // tests
  initial begin
    reset_n_in = 1'b0;
    power_on_n_in = 1'b0;
    strap = 1'b1;
    wake = 1'b0;
    repeat (8) @(negedge clk_in);
    reset_n_in = 1'b1;
    power_on_n_in = 1'b1;
    repeat (4) @(negedge clk_in);

    rdchk(8'h34, 32'h0000_00FF, 32'h0000_00DC, 1'b1);
    rdchk(8'hDC, 32'hFFFF_FFFF, 32'hFF0A_0001, 1'b1);
    chk(rdata_fs, 32'h520A_0001);
    rdchk(8'hE0, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    rdchk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
    $display("map test done");

    wr(8'hDC, 4'hF, 32'hFFFF_FFFF);
    wr(8'hE0, 4'hF, 32'h00FF_7EFC);
    rdchk(8'hDC, 32'hFFFF_FFFF, 32'hFF0A_0001, 1'b1);
    rdchk(8'hE0, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    $display("read-only test done");

    for (int i = 0; i < 4; i++) begin
      wr(8'hE0, 4'h1, i);
      chk({30'h0, ps}, i);
      chk({30'h0, ps_fs}, {30'h0, fs_exp[i]});
      rdchk(8'hE0, 32'h0000_0003, i, 1'b1);
    end
    wr(8'hE0, 4'h1, 32'h0);
    $display("power state test done");

    pulse_wake();
    chk({30'h0, pme_oe, pme_n}, 32'h0);
    rdchk(8'hE0, 32'h0000_FFFF, 32'h0000_8000, 1'b1);
    wr(8'hE0, 4'h3, 32'h0);
    rdchk(8'hE0, 32'h0000_FFFF, 32'h0000_8000, 1'b1);
    wr(8'hE0, 4'h2, 32'h0000_0100);
    @(negedge clk_in);
    chk({30'h0, pme_oe, pme_n}, 32'h2);
    rst_pulse(1'b0);
    rdchk(8'hE0, 32'h0000_FFFF, 32'h0000_8100, 1'b1);
    wr(8'hE0, 4'h2, 32'h0000_8100);
    @(negedge clk_in);
    chk({31'h0, pme_oe}, 32'h0);
    rdchk(8'hE0, 32'h0000_FFFF, 32'h0000_0100, 1'b1);
    // event and clear land on the same edge: the event must win
    fork
      wr(8'hE0, 4'h2, 32'h0000_8100);
      pulse_wake();
    join
    rdchk(8'hE0, 32'h0000_FFFF, 32'h0000_8100, 1'b1);
    $display("event test done");

    strap = 1'b0;
    rst_pulse(1'b1);
    rdchk(8'hDC, 32'hFFFF_FFFF, 32'h7F0A_0001, 1'b1);
    rdchk(8'hE0, 32'h0000_FFFF, 32'h0000_0000, 1'b1);
    wr(8'hE0, 4'h2, 32'h0000_0100);
    pulse_wake();
    chk({31'h0, pme_oe}, 32'h1);
    rst_pulse(1'b0);
    @(negedge clk_in);
    rdchk(8'hE0, 32'h0000_FFFF, 32'h0000_0000, 1'b1);
    chk({31'h0, pme_oe}, 32'h0);
    $display("strap test done");
    close_out();
  end
endmodule : pci_power_mgmt_capability_test

// ===== ppm_capability.sv
// power management capability structure of one function
// assumes config reads/writes are single-cycle strobes on the pci clock
`timescale 1ns/100ps
module ppm_capability #(
  parameter bit HIGH_SPEED   = 1'b1,
  parameter bit EVENT_CLOCK  = 1'b1,
  parameter bit HAS_DATA_REG = 1'b0
) (
  input  wire logic                  clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  power_on_n_in,
  input  wire logic                  d3cold_strap_pin_in,
  input  wire ppm_pkg::ppm_cfg_req_t cfg_req_in,
  output logic [31:0]                cfg_rdata_out,
  output logic                       cfg_hit_out,
  input  wire logic                  wake_event_in,
  output logic                       pme_n_out,
  output logic                       pme_oe_out,
  output logic [1:0]                 power_state_out
);

  // ==========================================================
  // strap capture
  logic cold_ok;
  logic strap_valid;

  ppm_strap u_strap (
    .clk_in      (clk_in),
    .reset_n_in  (power_on_n_in),
    .strap_in    (d3cold_strap_pin_in),
    .cold_ok_out (cold_ok),
    .valid_out   (strap_valid)
  );

  // ==========================================================
  // capability word
  logic [15:0] cap_word;
  logic [4:0]  event_support;
  logic        sticky;

  always_comb begin
    event_support    = {HIGH_SPEED & cold_ok, 1'b1, HIGH_SPEED, 1'b1, HIGH_SPEED};
    cap_word         = 16'h0000;
    cap_word[15:11]  = event_support;
    cap_word[10]     = HIGH_SPEED;
    cap_word[9]      = 1'b1;
    cap_word[8]      = HIGH_SPEED & ~HAS_DATA_REG;
    cap_word[7:6]    = ppm_pkg::STANDBY_CUR_VAL[1:0];
    cap_word[5]      = 1'b0;
    cap_word[4]      = 1'b0;
    cap_word[3]      = EVENT_CLOCK & (|event_support);
    cap_word[2:0]    = ppm_pkg::SPEC_REV_VAL;
  end

  // cold support needs the cold event bit; only high speed can report it
  assign sticky = cap_word[15];

  // ==========================================================
  // decode
  function automatic logic in_cap(input logic [7:0] a);
    in_cap = (a[7:2] == ppm_pkg::CAP_BASE[7:2]) || (a[7:2] == (ppm_pkg::CAP_BASE[7:2] + 6'h01));
  endfunction : in_cap

  logic wr_lo_dw;
  logic wr_hi_dw;
  assign wr_lo_dw = cfg_req_in.wr && (cfg_req_in.addr[7:2] == ppm_pkg::CAP_BASE[7:2]);
  assign wr_hi_dw = cfg_req_in.wr && (cfg_req_in.addr[7:2] == (ppm_pkg::CAP_BASE[7:2] + 6'h01));

  // ==========================================================
  // control/status state
  logic [1:0]  state_r;
  logic [3:0]  sel_r;
  logic        status_r;
  logic        enable_r;
  logic [1:0]  wstate;
  logic        state_ok;

  assign wstate = cfg_req_in.wdata[1:0];

  always_comb begin
    case (wstate)
      ppm_pkg::PPM_D0:    state_ok = 1'b1;
      ppm_pkg::PPM_D1:    state_ok = cap_word[9];
      ppm_pkg::PPM_D2:    state_ok = cap_word[10];
      ppm_pkg::PPM_D3HOT: state_ok = 1'b1;
      default:            state_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= ppm_pkg::PPM_D0;
    end else if (wr_hi_dw && cfg_req_in.be[0] && state_ok) begin
      state_r <= wstate;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sel_r <= ppm_pkg::DATA_SEL_RST;
    end else if (HAS_DATA_REG && wr_hi_dw && cfg_req_in.be[1]) begin
      sel_r <= cfg_req_in.wdata[12:9];
    end
  end

  // event bits survive function reset only with cold support; otherwise the first edge after it clears them
  logic ev_rst_n;
  assign ev_rst_n = power_on_n_in;

  logic fn_reset_seen_r;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fn_reset_seen_r <= 1'b1;
    end else begin
      fn_reset_seen_r <= 1'b0;
    end
  end

  logic clr_status;
  assign clr_status = wr_hi_dw && cfg_req_in.be[1] && cfg_req_in.wdata[ppm_pkg::CSR_STATUS_BIT];
  logic wr_enable_bit;
  assign wr_enable_bit = cfg_req_in.wdata[ppm_pkg::CSR_ENABLE_BIT];
  logic fn_clear;
  assign fn_clear = fn_reset_seen_r && !sticky;

  always_ff @(posedge clk_in or negedge ev_rst_n) begin
    if (!ev_rst_n) begin
      status_r <= 1'b0;
    end else if (fn_clear) begin
      status_r <= 1'b0;
    end else if (wake_event_in) begin
      status_r <= 1'b1; // set wins over clear
    end else if (clr_status) begin
      status_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge ev_rst_n) begin
    if (!ev_rst_n) begin
      enable_r <= 1'b0;
    end else if (fn_clear) begin
      enable_r <= 1'b0;
    end else if (wr_hi_dw && cfg_req_in.be[1]) begin
      enable_r <= wr_enable_bit & (|event_support);
    end
  end

  // ==========================================================
  // event pin: open-drain, driven low while enabled and pending
  logic pme_r;
  always_ff @(posedge clk_in or negedge ev_rst_n) begin
    if (!ev_rst_n) begin
      pme_r <= 1'b0;
    end else begin
      pme_r <= status_r && enable_r && !clr_status;
    end
  end
  assign pme_n_out  = 1'b0;
  assign pme_oe_out = pme_r;

  logic [15:0] csr_word;
  always_comb begin
    csr_word     = 16'h0000;
    csr_word[15] = status_r;
    csr_word[14:13] = ppm_pkg::DATA_SCALE_VAL;
    csr_word[12:9]  = HAS_DATA_REG ? sel_r : 4'h0;
    csr_word[8]     = enable_r;
    csr_word[1:0]   = state_r;
  end

  // ==========================================================
  // read data
  logic [31:0] rd_nxt;
  logic [31:0] rdata_r;
  logic        hit_r;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (cfg_req_in.addr[7:2] == ppm_pkg::CAP_PTR_ADDR[7:2]) begin
      rd_nxt[7:0] = ppm_pkg::CAP_BASE;
    end else if (cfg_req_in.addr[7:2] == ppm_pkg::CAP_BASE[7:2]) begin
      rd_nxt = {cap_word, ppm_pkg::CAP_LINK_VAL, ppm_pkg::CAP_CODE_VAL};
    end else if (in_cap(cfg_req_in.addr)) begin
      rd_nxt = {8'h00, ppm_pkg::BRIDGE_VAL, csr_word};
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= 32'h0000_0000;
      hit_r   <= 1'b0;
    end else begin
      rdata_r <= cfg_req_in.rd ? rd_nxt : 32'h0000_0000;
      hit_r   <= (cfg_req_in.rd || cfg_req_in.wr) &&
                 (in_cap(cfg_req_in.addr) || cfg_req_in.addr[7:2] == ppm_pkg::CAP_PTR_ADDR[7:2]);
    end
  end

  assign cfg_rdata_out   = rdata_r;
  assign cfg_hit_out     = hit_r;
  assign power_state_out = state_r;

  // ==========================================================
  // checks
  property code_link_p;
    @(posedge clk_in) disable iff (!reset_n_in)
      (cfg_req_in.rd && cfg_req_in.addr[7:2] == ppm_pkg::CAP_BASE[7:2]) |=> (cfg_rdata_out[15:0] == 16'h0001);
  endproperty
  code_link_a: assert property (code_link_p) else $error("code or link wrong");

  ptr_read_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cfg_req_in.rd && cfg_req_in.addr[7:2] == 6'h0D) |=> (cfg_rdata_out == 32'h0000_00DC))
    else $error("capability pointer wrong");

  rev_field_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cfg_req_in.rd && cfg_req_in.addr[7:2] == 6'h37) |=> (cfg_rdata_out[18:16] == 3'b010 && cfg_rdata_out[21:20] == 2'b00))
    else $error("revision or reserved bits wrong");

  sequence set_clash_s;
    wake_event_in && clr_status && !fn_clear;
  endsequence
  status_set_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (wake_event_in && !(fn_reset_seen_r && !sticky)) |=> status_r)
    else $error("event status not set");
  clash_keep_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    set_clash_s |=> status_r) else $error("clear beat set");

  pme_gate_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    pme_oe_out |-> $past(enable_r)) else $error("event pin without enable");

  bad_state_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (wr_hi_dw && cfg_req_in.be[0] && !state_ok) |=> $stable(state_r)) else $error("bad state taken");

  good_state_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (wr_hi_dw && cfg_req_in.be[0] && state_ok) |=> (power_state_out == $past(wstate))) else $error("state not taken");

  bridge_zero_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cfg_req_in.rd && cfg_req_in.addr[7:2] == 6'h38) |=> (cfg_rdata_out[31:16] == 16'h0000 && cfg_rdata_out[7:2] == 6'h00))
    else $error("bridge byte or reserved nonzero");

  // ==========================================================
  // register contents; every read answers one edge after its strobe
  cap_fixed_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cfg_req_in.rd && cfg_req_in.addr[7:2] == 6'h37) |=> (cfg_rdata_out[30] && cfg_rdata_out[28] && cfg_rdata_out[25]))
    else $error("fixed capability bits not set");

  speed_bits_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cfg_req_in.rd && cfg_req_in.addr[7:2] == 6'h37) |=> (({cfg_rdata_out[29], cfg_rdata_out[27], cfg_rdata_out[26]} ==
      {3{HIGH_SPEED}}) && (cfg_rdata_out[24] == (HIGH_SPEED & ~HAS_DATA_REG))))
    else $error("speed dependent capability bits wrong");

  cold_bit_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cfg_req_in.rd && cfg_req_in.addr[7:2] == 6'h37) |=> (cfg_rdata_out[31] == (HIGH_SPEED & cold_ok)))
    else $error("cold event bit does not follow strap");

  low_cap_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cfg_req_in.rd && cfg_req_in.addr[7:2] == 6'h37) |=> (cfg_rdata_out[23:21] == 3'b000 && cfg_rdata_out[19] == EVENT_CLOCK))
    else $error("current, init or clock bit wrong");

  data_fields_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cfg_req_in.rd && cfg_req_in.addr[7:2] == 6'h38 && !HAS_DATA_REG) |=> (cfg_rdata_out[14:9] == 6'h00))
    else $error("data scale or selector nonzero");

  state_read_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (cfg_req_in.rd && cfg_req_in.addr[7:2] == 6'h38) |=> (cfg_rdata_out[1:0] == $past(power_state_out)))
    else $error("power state read back wrong");

  state_reset_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(reset_n_in) |-> (power_state_out == 2'b00))
    else $error("power state not zero after reset");

  hit_on_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ((cfg_req_in.rd || cfg_req_in.wr) && (in_cap(cfg_req_in.addr) || cfg_req_in.addr[7:2] == 6'h0D)) |=> cfg_hit_out)
    else $error("mapped access not claimed");

  hit_off_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!(cfg_req_in.rd || cfg_req_in.wr) || !(in_cap(cfg_req_in.addr) || cfg_req_in.addr[7:2] == 6'h0D)) |=> !cfg_hit_out)
    else $error("unmapped access claimed");

  rdata_idle_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !cfg_req_in.rd |=> (cfg_rdata_out == 32'h0000_0000))
    else $error("read data not zero when idle");

  // ==========================================================
  // event status, enable and pin
  status_clear_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (clr_status && !wake_event_in && !fn_clear) |=> !status_r)
    else $error("event status not cleared");

  event_keep_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (status_r && !clr_status && !fn_clear) |=> status_r)
    else $error("event status lost without clear");

  enable_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (wr_hi_dw && cfg_req_in.be[1] && !fn_clear) |=> (enable_r == $past(wr_enable_bit)))
    else $error("event enable not written");

  sticky_keep_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (fn_reset_seen_r && sticky && !wake_event_in && !wr_hi_dw) |=> ($stable(status_r) && $stable(enable_r)))
    else $error("sticky event bits lost on reset");

  plain_clear_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    fn_clear |=> (!status_r && !enable_r))
    else $error("event bits kept without cold support");

  pme_drop_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clr_status |=> !pme_oe_out)
    else $error("event pin held after clear");

  // event to pin takes two edges: status first, then the pin
  sequence wake_armed_s;
    wake_event_in && enable_r && !wr_hi_dw && !fn_clear;
  endsequence
  sequence csr_quiet_s;
    !wr_hi_dw && !fn_clear;
  endsequence
  pme_raise_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wake_armed_s ##1 csr_quiet_s |=> pme_oe_out) else $error("event pin not raised");

  // strap is caught once; a later change would silently flip the sticky mode
  strap_done_a: assert property (@(posedge clk_in) disable iff (!power_on_n_in)
    strap_valid |=> $stable(cold_ok))
    else $error("strap value changed after latch");

endmodule : ppm_capability

// ===== ppm_host.sv
// host bridge model: issues configuration reads and writes
// assumes the bench launches requests on the falling edge of clk_in
`timescale 1ns/100ps
module ppm_host (
  input  wire logic             clk_in,
  input  wire logic [31:0]      rdata_in,
  input  wire logic             hit_in,
  output ppm_pkg::ppm_cfg_req_t req_out
);
  // ==========================================
  // configuration cycles
  initial req_out = '0;

  // one-cycle strobe; answer stands for one cycle, so sample at the next falling edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
                      output logic [31:0] d, output logic h);
    @(negedge clk_in);
    req_out = '{rd: ~w, wr: w, addr: a, be: be, wdata: wd};
    @(negedge clk_in);
    req_out = '0;
    d = rdata_in;
    h = hit_in;
  endtask : xfer
endmodule : ppm_host

// ===== ppm_pkg.sv
// power management capability: offsets, field layouts, reset values
// assumes a configuration access port with byte enables on a dword
package ppm_pkg;

  // ==========================================================
  // placement in configuration space
  localparam logic [7:0] CAP_PTR_ADDR    = 8'h34;
  localparam logic [7:0] CAP_BASE        = 8'hDC;
  localparam logic [7:0] OFS_CODE        = 8'h00;
  localparam logic [7:0] OFS_LINK        = 8'h01;
  localparam logic [7:0] OFS_CAPW        = 8'h02;
  localparam logic [7:0] OFS_CSR         = 8'h04;
  localparam logic [7:0] OFS_BRIDGE      = 8'h06;
  localparam logic [7:0] OFS_DATA        = 8'h07;

  // ==========================================================
  // fixed values
  localparam logic [7:0] CAP_CODE_VAL    = 8'h01;
  localparam logic [7:0] CAP_LINK_VAL    = 8'h00;
  localparam logic [7:0] BRIDGE_VAL      = 8'h00;
  localparam logic [2:0] SPEC_REV_VAL    = 3'h2;
  localparam logic [2:0] STANDBY_CUR_VAL = 3'h0;
  localparam logic [1:0] DATA_SCALE_VAL  = 2'h0;
  localparam logic [3:0] DATA_SEL_RST    = 4'h0;

  // ==========================================================
  // field positions in the control/status word and the capability word
  localparam int CSR_STATUS_BIT = 15;
  localparam int CSR_ENABLE_BIT = 8;
  localparam int CAP_SUPPORT_LO = 11;

  // ==========================================================
  // strap settle: edges after power-on release before the latch
  localparam logic [1:0] STRAP_LATCH_CNT = 2'h2;

  // ==========================================================
  // power states
  typedef enum logic [1:0] {
    PPM_D0    = 2'b00,
    PPM_D1    = 2'b01,
    PPM_D2    = 2'b10,
    PPM_D3HOT = 2'b11
  } ppm_state_t;

  // configuration access carrier
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } ppm_cfg_req_t;

endpackage : ppm_pkg

// ===== ppm_strap.sv
// strap capture for cold-state support
// assumes the strap pin is static after power-on
`timescale 1ns/100ps
module ppm_strap (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic strap_in,
  output logic      cold_ok_out,
  output logic      valid_out
);

  logic       sync1_r;
  logic       sync2_r;
  logic       done_r;
  logic [1:0] cnt_r;

  // ==========================================================
  // two-stage synchroniser
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= strap_in;
      sync2_r <= sync1_r;
    end
  end

  // latch once, on the third edge after release, when the strap has crossed both flops
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      done_r      <= 1'b0;
      cnt_r       <= 2'h0;
      cold_ok_out <= 1'b0;
    end else if (!done_r) begin
      if (cnt_r == ppm_pkg::STRAP_LATCH_CNT) begin
        done_r      <= 1'b1;
        cold_ok_out <= sync2_r;
      end else begin
        cnt_r <= cnt_r + 2'h1;
      end
    end
  end

  assign valid_out = done_r;

endmodule : ppm_strap
